// >>> core/system_address_decoder.sv
// memory address decoder routing requests to dram, hub link, graphics port
//
// Functional notes
// - expansion area: eight 16 KB four-state segments
// - extended firmware: four segments, read/write attributes
// - system firmware segment disabled after reset
// - hole enabled: 15-16 MB goes to hub
// - top smm segment sized 128 KB to 1 MB
// - top segment to dram only for qualified smm
// - non-smm cpu access to enabled segment specially terminated
// - disabled smm ranges decode as normal memory
// - hub/graphics smm reads see zero, writes dropped
// - hub/graphics interrupt-window writes become messages
// - interrupt message completes with target ready
// - high smm window remapped onto compatible smm dram
// - aperture accesses translated then sent to dram
// - aperture size 4-256 MB, base low bits zero
// - aperture size resets to 256 MB
// - both graphics windows inclusive go to graphics
// - unclaimed space above top of memory to hub
// - graphics port shadow-area accesses always to dram
`timescale 1ns/1ps
module system_address_decoder
  import sad_pkg::*;
#(
  parameter int XLAT_AW = 10
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    req_valid,
  input  wire sad_pkg::source_t        req_source,
  input  wire logic                    req_write,
  input  wire logic                    req_smm_code,
  input  wire logic [31:0]             req_addr,
  input  wire logic [31:0]             req_wdata,
  input  wire logic                    shadow_attr_load,
  input  wire logic [sad_pkg::ATTR_W-1:0] shadow_attr_value,
  output logic      [sad_pkg::ATTR_W-1:0] shadow_segment_attributes,
  input  wire logic                    memory_hole_enable,
  input  wire logic [31:0]             top_of_low_memory,
  input  wire logic [1:0]              top_smm_segment_size,
  input  wire logic                    top_smm_segment_enable,
  input  wire logic                    high_smm_window_enable,
  input  wire logic                    global_smm_enable,
  input  wire logic                    smm_space_open,
  input  wire logic [31:0]             aperture_base_value,
  output logic      [31:0]             aperture_base,
  input  wire logic                    aperture_size_load,
  input  wire logic [sad_pkg::APERTURE_SIZE_W-1:0] aperture_size_value,
  output logic      [sad_pkg::APERTURE_SIZE_W-1:0] aperture_size,
  input  wire logic [31:0]             graphics_window_base,
  input  wire logic [31:0]             graphics_window_limit,
  input  wire logic [31:0]             prefetch_window_base,
  input  wire logic [31:0]             prefetch_window_limit,
  input  wire logic                    xlat_wr_en,
  input  wire logic [XLAT_AW-1:0]      xlat_wr_index,
  input  wire logic [sad_pkg::FRAME_W-1:0] xlat_wr_frame,
  output logic                         rsp_valid,
  output sad_pkg::target_t             rsp_target,
  output logic                         rsp_write,
  output logic      [31:0]             rsp_addr,
  output logic                         intr_msg_valid,
  output logic      [31:0]             intr_msg_addr,
  output logic      [31:0]             intr_msg_data,
  output logic                         bus_target_ready
);

  // ****************************************************************
  // configuration state
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shadow_segment_attributes <= SHADOW_ATTR_RESET;
    end else if (shadow_attr_load) begin
      shadow_segment_attributes <= shadow_attr_value;
    end
  end

  // codes above 256 MB are refused so the span never leaves the set
  logic [2:0]  next_size;
  logic [31:0] ap_mask;
  logic [31:0] ap_base_m;
  assign next_size = aperture_size_load && aperture_size_value <= APERTURE_SIZE_256MB
                     ? aperture_size_value : aperture_size;
  assign ap_mask   = aperture_span(aperture_size) - 32'h0000_0001;
  assign ap_base_m = aperture_base_value & ~ap_mask;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aperture_size <= APERTURE_SIZE_256MB;
    end else begin
      aperture_size <= next_size;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aperture_base <= ZERO_ADDR;
    end else begin
      aperture_base <= aperture_base_value &
                       ~(aperture_span(next_size) - 32'h0000_0001);
    end
  end

  // ****************************************************************
  // range hits
  // ****************************************************************
  logic        is_cpu;
  logic        in_shadow;
  logic [3:0]  seg;
  logic        seg_rd;
  logic        seg_wr;
  logic        in_hole;
  logic        in_intr;
  logic        in_high;
  logic [31:0] top_smm_segment_base;
  logic        in_top_smm_segment;
  logic        smm_ok;
  logic        in_ap;
  logic        in_gfx_win;
  logic [31:0] ap_page;

  assign is_cpu    = (req_source == SRC_CPU);
  assign in_shadow = req_addr >= SHADOW_BASE && req_addr <= SHADOW_END;
  assign seg       = shadow_segment(req_addr);
  assign seg_rd    = shadow_segment_attributes[{seg, ATTR_READ_BIT}];
  assign seg_wr    = shadow_segment_attributes[{seg, ATTR_WRITE_BIT}];
  assign in_hole   = req_addr >= HOLE_BASE && req_addr <= HOLE_END;
  assign in_intr   = req_addr >= INTR_BASE && req_addr <= INTR_END;
  assign in_high   = req_addr >= HIGH_SMM_BASE && req_addr <= HIGH_SMM_END;
  assign top_smm_segment_base = top_of_low_memory
                     - top_smm_segment_bytes(top_smm_segment_size);
  assign in_top_smm_segment   = req_addr >= top_smm_segment_base && req_addr < top_of_low_memory;
  assign smm_ok    = is_cpu && global_smm_enable
                     && (smm_space_open || req_smm_code);
  assign in_ap     = (req_addr & ~ap_mask) == ap_base_m;
  assign in_gfx_win = (req_addr >= graphics_window_base &&
                       req_addr <= graphics_window_limit) ||
                      (req_addr >= prefetch_window_base &&
                       req_addr <= prefetch_window_limit);
  assign ap_page   = (req_addr - ap_base_m) >> PAGE_SHIFT;

  // ****************************************************************
  // decode
  // ****************************************************************
  target_t     next_target;
  logic [31:0] next_addr;
  logic        next_xlat;

  // priority: shadow, hole, interrupt window, high smm, top segment,
  // low dram, aperture, graphics windows, subtractive hub
  always_comb begin
    next_target = TGT_HUB;
    next_addr   = req_addr;
    next_xlat   = 1'b0;
    if (in_shadow) begin
      if (!is_cpu) begin
        next_target = TGT_DRAM;
      end else if (req_write ? seg_wr : seg_rd) begin
        next_target = TGT_DRAM;
      end else begin
        next_target = TGT_HUB;
      end
    end else if (in_hole && memory_hole_enable) begin
      next_target = TGT_HUB;
    end else if (in_intr && req_write && !is_cpu) begin
      next_target = TGT_INTR;
    end else if (in_high && high_smm_window_enable && global_smm_enable
                 && (smm_ok || !is_cpu)) begin
      if (smm_ok) begin
        next_target = TGT_DRAM;
        next_addr   = COMPAT_SMM_BASE | (req_addr & HIGH_SMM_OFS);
      end else begin
        next_target = req_write ? TGT_DISCARD : TGT_DRAM;
        next_addr   = ZERO_ADDR;
      end
    end else if (in_top_smm_segment && top_smm_segment_enable) begin
      if (smm_ok) begin
        next_target = TGT_DRAM;
      end else if (!is_cpu) begin
        next_target = req_write ? TGT_DISCARD : TGT_DRAM;
        next_addr   = ZERO_ADDR;
      end else begin
        next_target = TGT_SPECIAL;
      end
    end else if (req_addr < top_of_low_memory) begin
      next_target = TGT_DRAM;
    end else if (in_ap) begin
      next_target = TGT_DRAM;
      next_xlat   = 1'b1;
    end else if (in_gfx_win) begin
      next_target = TGT_GFX;
    end
  end

  // ****************************************************************
  // stage 1: decoded request, translation lookup in flight
  // ****************************************************************
  logic        s1_valid;
  target_t     s1_target;
  logic        s1_write;
  logic        s1_xlat;
  logic [31:0] s1_addr;
  logic [31:0] s1_wdata;
  logic [FRAME_W-1:0] xlat_frame;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_valid  <= 1'b0;
      s1_target <= TGT_HUB;
      s1_write  <= 1'b0;
      s1_xlat   <= 1'b0;
      s1_addr   <= ZERO_ADDR;
      s1_wdata  <= ZERO_ADDR;
    end else begin
      s1_valid  <= req_valid;
      s1_target <= next_target;
      s1_write  <= req_write;
      s1_xlat   <= next_xlat;
      s1_addr   <= next_addr;
      s1_wdata  <= req_wdata;
    end
  end

  // only the low page bits index the local table; larger apertures
  // alias onto it, trading reach for area
  xlat_table_mem #(
    .AW (XLAT_AW),
    .DW (FRAME_W)
  ) u_xlat (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (xlat_wr_en),
    .wr_index (xlat_wr_index),
    .wr_data  (xlat_wr_frame),
    .rd_index (ap_page[XLAT_AW-1:0]),
    .rd_data  (xlat_frame)
  );

  // ****************************************************************
  // stage 2: routed answer and interrupt message
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_valid  <= 1'b0;
      rsp_target <= TGT_HUB;
      rsp_write  <= 1'b0;
      rsp_addr   <= ZERO_ADDR;
    end else begin
      rsp_valid  <= s1_valid;
      rsp_target <= s1_target;
      rsp_write  <= s1_write;
      rsp_addr   <= s1_xlat ? {xlat_frame, s1_addr[PAGE_SHIFT-1:0]}
                            : s1_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      intr_msg_valid   <= 1'b0;
      bus_target_ready <= 1'b0;
      intr_msg_addr    <= ZERO_ADDR;
      intr_msg_data    <= ZERO_ADDR;
    end else begin
      intr_msg_valid   <= s1_valid && s1_target == TGT_INTR;
      bus_target_ready <= s1_valid && s1_target == TGT_INTR;
      intr_msg_addr    <= s1_addr;
      intr_msg_data    <= s1_wdata;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence gfx_shadow_req;
    req_valid && req_source == SRC_GFX && in_shadow;
  endsequence
  sequence routed_to(target_t t);
    ##2 rsp_valid && rsp_target == t;
  endsequence

  AST_GFX_SHADOW: assert property (
    gfx_shadow_req |-> routed_to(TGT_DRAM))
    else $error("graphics shadow access not sent to dram");

  AST_SHADOW_PARTIAL: assert property (
    req_valid && is_cpu && in_shadow && !req_write && !seg_rd
    |-> routed_to(TGT_HUB))
    else $error("read of read-disabled segment not sent to hub");

  AST_HOLE: assert property (
    req_valid && in_hole && memory_hole_enable |-> routed_to(TGT_HUB))
    else $error("hole access not forwarded to hub");

  AST_INTR_MSG: assert property (
    req_valid && in_intr && req_write && !is_cpu
    |-> ##2 intr_msg_valid && rsp_target == TGT_INTR
        && intr_msg_data == $past(req_wdata, 2))
    else $error("interrupt window write not converted");

  AST_BUS_TARGET_READY: assert property (
    intr_msg_valid |-> bus_target_ready && rsp_valid && rsp_write)
    else $error("interrupt message without target ready");

  AST_TOP_SMM_SEGMENT_SPECIAL: assert property (
    req_valid && is_cpu && !smm_ok && in_top_smm_segment && top_smm_segment_enable
    && !in_shadow && !in_hole && !in_high && !in_intr
    |-> routed_to(TGT_SPECIAL))
    else $error("non-smm top segment access not specially terminated");

  AST_SMM_BLOCK: assert property (
    req_valid && !is_cpu && in_top_smm_segment && top_smm_segment_enable
    && req_write && !in_shadow && !in_hole && !in_intr && !in_high
    |-> routed_to(TGT_DISCARD))
    else $error("hub or graphics smm write not discarded");

  AST_HIGH_REMAP: assert property (
    req_valid && in_high && smm_ok && high_smm_window_enable
    |-> ##2 rsp_target == TGT_DRAM && rsp_addr ==
        (COMPAT_SMM_BASE | ($past(req_addr, 2) & HIGH_SMM_OFS)))
    else $error("high smm access not remapped");

  AST_APERTURE_BASE_ZERO: assert property (
    ##1 (aperture_base & ap_mask) == ZERO_ADDR)
    else $error("aperture base low bits not zero");

  AST_APERTURE_SIZE_RESET: assert property (
    $fell(rst) |-> aperture_size == APERTURE_SIZE_256MB)
    else $error("aperture size not 256 MB after reset");

endmodule : system_address_decoder

// >>> core/sad_pkg.sv
// shared constants, types and decode helpers of the system address decoder
package sad_pkg;

  // ****************************************************************
  // request sources and routing targets
  // ****************************************************************
  typedef enum logic [1:0] {SRC_CPU, SRC_HUB, SRC_GFX} source_t;
  typedef enum logic [2:0] {
    TGT_DRAM, TGT_HUB, TGT_GFX, TGT_INTR, TGT_SPECIAL, TGT_DISCARD
  } target_t;

  // ****************************************************************
  // fixed address ranges
  // ****************************************************************
  localparam logic [31:0] SHADOW_BASE     = 32'h000c_0000;
  localparam logic [31:0] SHADOW_END      = 32'h000f_ffff;
  localparam logic [31:0] SYS_FW_BASE     = 32'h000f_0000;
  localparam logic [31:0] HOLE_BASE       = 32'h00f0_0000;
  localparam logic [31:0] HOLE_END        = 32'h00ff_ffff;
  localparam logic [31:0] INTR_BASE       = 32'hfee0_0000;
  localparam logic [31:0] INTR_END        = 32'hfeef_ffff;
  localparam logic [31:0] HIGH_SMM_BASE   = 32'hfeda_0000;
  localparam logic [31:0] HIGH_SMM_END    = 32'hfedb_ffff;
  localparam logic [31:0] COMPAT_SMM_BASE = 32'h000a_0000;
  localparam logic [31:0] HIGH_SMM_OFS    = 32'h0001_ffff;
  localparam logic [31:0] ZERO_ADDR       = 32'h0000_0000;

  // ****************************************************************
  // shadow segments: 16 KB each except the 64 KB segment 12, two attribute bits per segment
  // ****************************************************************
  localparam int          SHADOW_SEGS     = 13;
  localparam int          ATTR_W          = 2 * SHADOW_SEGS;
  localparam int          SEG_SHIFT       = 14;
  localparam logic [3:0]  SYS_FW_SEG      = 4'hc;
  localparam logic [0:0]  ATTR_READ_BIT   = 1'h0;
  localparam logic [0:0]  ATTR_WRITE_BIT  = 1'h1;
  localparam logic [ATTR_W-1:0] SHADOW_ATTR_RESET = 26'h000_0000;

  // ****************************************************************
  // top smm segment and graphics aperture
  // ****************************************************************
  localparam logic [31:0] TOP_SMM_SEGMENT_MIN_BYTES  = 32'h0002_0000;
  localparam int          APERTURE_SIZE_W        = 3;
  localparam logic [2:0]  APERTURE_SIZE_256MB    = 3'h6;
  localparam logic [31:0] APERTURE_MIN    = 32'h0040_0000;
  localparam int          PAGE_SHIFT      = 12;
  localparam int          FRAME_W         = 20;

  // size code 0..3 selects 128 KB, 256 KB, 512 KB, 1 MB
  function automatic logic [31:0] top_smm_segment_bytes(input logic [1:0] code);
    top_smm_segment_bytes = TOP_SMM_SEGMENT_MIN_BYTES << code;
  endfunction : top_smm_segment_bytes

  // size code 0..6 selects 4 MB up to 256 MB
  function automatic logic [31:0] aperture_span(input logic [2:0] code);
    aperture_span = APERTURE_MIN << code;
  endfunction : aperture_span

  // segments 0..11 are 16 KB each, everything from the system firmware
  // base up is the single segment 12
  function automatic logic [3:0] shadow_segment(input logic [31:0] a);
    logic [31:0] rel;
    rel = (a - SHADOW_BASE) >> SEG_SHIFT;
    if (a >= SYS_FW_BASE) begin
      shadow_segment = SYS_FW_SEG;
    end else begin
      shadow_segment = rel[3:0];
    end
  endfunction : shadow_segment

endpackage : sad_pkg

// >>> core/xlat_table_mem.sv
// local copy of the aperture translation table, registered read
`timescale 1ns/1ps
module xlat_table_mem #(
  parameter int AW = 10,
  parameter int DW = 20
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_index,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_index,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] table_mem [2**AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      table_mem[wr_index] <= wr_data;
    end
  end

  // entries are not reset; only the read register is
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= table_mem[rd_index];
    end
  end

endmodule : xlat_table_mem

// >>> verif/request_agent.sv
// far-side request agent and platform address map for the decoder
`timescale 1ns/1ps
module request_agent
  import sad_pkg::*;
(
  input  wire logic        core_clk,
  output logic             req_valid,
  output sad_pkg::source_t req_source,
  output logic             req_write,
  output logic             req_smm_code,
  output logic [31:0]      req_addr,
  output logic [31:0]      req_wdata,
  output logic [31:0]      top_of_low_memory,
  output logic [31:0]      graphics_window_base,
  output logic [31:0]      graphics_window_limit,
  output logic [31:0]      prefetch_window_base,
  output logic [31:0]      prefetch_window_limit,
  output logic [31:0]      aperture_base_value
);
  // ****************************************
  // platform map above top of memory
  // ****************************************
  initial begin
    top_of_low_memory     = 32'h1000_0000;
    graphics_window_base  = 32'hc000_0000;
    graphics_window_limit = 32'hc0ff_ffff;
    prefetch_window_base  = 32'hc100_0000;
    prefetch_window_limit = 32'hc1ff_ffff;
    // low bits are masked by the size, so every size stays clear
    aperture_base_value   = 32'hdfff_ffff;
    req_valid             = 1'h0;
    req_source            = SRC_CPU;
    req_write             = 1'h0;
    req_smm_code          = 1'h0;
    req_addr              = 32'h0000_0000;
    req_wdata             = 32'h0000_0000;
  end

  task automatic issue(input source_t s, input logic w, input logic c,
                       input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req_valid    <= 1'h1;
    req_source   <= s;
    req_write    <= w;
    req_smm_code <= c;
    req_addr     <= a;
    req_wdata    <= d;
  endtask : issue

  // stale values are inverted so a released bus never decodes by luck
  task automatic idle();
    @(posedge core_clk);
    req_valid <= 1'h0;
    req_addr  <= ~req_addr;
    req_wdata <= ~req_wdata;
  endtask : idle
endmodule : request_agent

// >>> verif/tb_system_address_decoder.sv
// self-checking bench for the system address decoder
`timescale 1ns/1ps
module tb_system_address_decoder;
  import sad_pkg::*;
  typedef struct packed {
    target_t     tgt;
    logic [31:0] addr;
    logic        w;
    logic [31:0] d;
  } exp_t;
  localparam logic NO  = 1'h0;
  localparam logic YES = 1'h1;
  logic               core_clk = 1'h0;
  logic               rst = 1'h1;
  logic               req_valid, req_write, req_smm_code;
  source_t            req_source;
  logic [31:0]        req_addr, req_wdata, top_of_low_memory;
  logic [31:0]        graphics_window_base, graphics_window_limit;
  logic [31:0]        prefetch_window_base, prefetch_window_limit;
  logic [31:0]        aperture_base_value, aperture_base;
  logic               shadow_attr_load = 1'h0;
  logic [ATTR_W-1:0]  shadow_attr_value = '0;
  logic [ATTR_W-1:0]  shadow_segment_attributes, v;
  logic               memory_hole_enable = 1'h0;
  logic               top_smm_segment_enable = 1'h0;
  logic               high_smm_window_enable = 1'h0;
  logic               global_smm_enable = 1'h0;
  logic               smm_space_open = 1'h0;
  logic [1:0]         top_smm_segment_size = 2'h0;
  logic               aperture_size_load = 1'h0;
  logic [2:0]         aperture_size_value = 3'h0;
  logic [2:0]         aperture_size;
  logic               xlat_wr_en = 1'h0;
  logic [3:0]         xlat_wr_index = 4'h0;
  logic [FRAME_W-1:0] xlat_wr_frame = '0;
  logic [FRAME_W-1:0] fr [16];
  logic               rsp_valid, rsp_write, intr_msg_valid;
  logic               bus_target_ready;
  target_t            rsp_target;
  logic [31:0]        rsp_addr, intr_msg_addr, intr_msg_data, ad, bs;
  exp_t               expq [$];
  int                 n_errors = 0;
  int                 samples_checked = 0;
  int                 seed = 32'h63e0906c;
  int                 m;

  always #12.5 core_clk = ~core_clk;

  request_agent agent (.core_clk, .req_valid, .req_source, .req_write,
    .req_smm_code, .req_addr, .req_wdata, .top_of_low_memory,
    .graphics_window_base, .graphics_window_limit,
    .prefetch_window_base, .prefetch_window_limit, .aperture_base_value);

  system_address_decoder #(.XLAT_AW(4)) dut (.core_clk, .rst, .req_valid,
    .req_source, .req_write, .req_smm_code, .req_addr, .req_wdata,
    .shadow_attr_load, .shadow_attr_value, .shadow_segment_attributes,
    .memory_hole_enable, .top_of_low_memory, .top_smm_segment_size,
    .top_smm_segment_enable, .high_smm_window_enable, .global_smm_enable,
    .smm_space_open, .aperture_base_value, .aperture_base,
    .aperture_size_load, .aperture_size_value, .aperture_size,
    .graphics_window_base, .graphics_window_limit, .prefetch_window_base,
    .prefetch_window_limit, .xlat_wr_en, .xlat_wr_index, .xlat_wr_frame,
    .rsp_valid, .rsp_target, .rsp_write, .rsp_addr, .intr_msg_valid,
    .intr_msg_addr, .intr_msg_data, .bus_target_ready);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("TB: errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic rq(input source_t s, input logic w, input logic [31:0] a,
                    input target_t t, input logic [31:0] ea,
                    input logic c = 1'h0);
    logic [31:0] d;
    d = $random(seed);
    expq.push_back('{t, ea, w, d});
    agent.issue(s, w, c, a, d);
  endtask : rq

  task automatic rqa(input source_t s, input logic w, input logic [31:0] a,
                     input target_t t, input logic c = 1'h0);
    rq(s, w, a, t, a, c);
  endtask : rqa

  task automatic flg(input logic h, g, t, hi, o, input logic [1:0] z);
    agent.idle();
    memory_hole_enable     <= h;
    global_smm_enable      <= g;
    top_smm_segment_enable <= t;
    high_smm_window_enable <= hi;
    smm_space_open         <= o;
    top_smm_segment_size   <= z;
  endtask : flg

  task automatic load_attr(input logic [ATTR_W-1:0] val);
    agent.idle();
    shadow_attr_load  <= YES;
    shadow_attr_value <= val;
    @(posedge core_clk);
    shadow_attr_load <= NO;
    @(negedge core_clk);
    check(32'(shadow_segment_attributes), 32'(val));
  endtask : load_attr

  task automatic load_size(input logic [2:0] c);
    agent.idle();
    aperture_size_load  <= YES;
    aperture_size_value <= c;
    @(posedge core_clk);
    aperture_size_load <= NO;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : load_size

  // ****************************************
  // response monitor
  // ****************************************
  always @(negedge core_clk) begin
    exp_t e;
    if (rsp_valid === 1'h1) begin
      if (expq.size() == 0) begin
        n_errors++;
        $display("[FAIL] t=%0t seen=%h exp=none", $time, rsp_addr);
      end else begin
        e = expq.pop_front();
        check(32'(rsp_target), 32'(e.tgt));
        if (e.tgt != TGT_DISCARD) begin
          check(rsp_addr, e.addr);
        end
        check(32'(rsp_write), 32'(e.w));
        check(32'(intr_msg_valid), 32'(e.tgt == TGT_INTR));
        check(32'(bus_target_ready), 32'(e.tgt == TGT_INTR));
        if (e.tgt == TGT_INTR) begin
          check(intr_msg_data, e.d);
          check(intr_msg_addr, e.addr);
        end
      end
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= NO;
    repeat (3) @(negedge core_clk);
    check(32'(aperture_size), 32'h6);
    check(32'(shadow_segment_attributes), 32'h0);
    check(aperture_base, 32'hd000_0000);
    rqa(SRC_CPU, NO, 32'h000f_8000, TGT_HUB);
    rqa(SRC_CPU, YES, 32'h000f_fffc, TGT_HUB);
    // each pass rotates the states so every segment sees all four
    for (int st = 0; st < 4; st++) begin
      for (int s = 0; s < 13; s++) begin
        v[2*s +: 2] = 2'(s + st);
      end
      load_attr(v);
      for (int s = 0; s < 13; s++) begin
        ad = 32'h000c_0000 + (s << 14) + ($random(seed) & 32'h3ffc);
        ad = (s == 12) ? (ad | 32'hc000) : ad;
        rqa(SRC_CPU, NO, ad, v[2*s] ? TGT_DRAM : TGT_HUB);
        rqa(SRC_CPU, YES, ad, v[2*s+1] ? TGT_DRAM : TGT_HUB);
        rqa(source_t'(1 + st % 2), st[1], ad, TGT_DRAM);
      end
    end
    for (int h = 0; h < 2; h++) begin
      flg(h[0], NO, NO, NO, NO, 2'h0);
      rqa(SRC_CPU, NO, 32'h00f0_0000, h ? TGT_HUB : TGT_DRAM);
      rqa(SRC_HUB, YES, 32'h00ff_fffc, h ? TGT_HUB : TGT_DRAM);
      rqa(SRC_CPU, NO, 32'h00ef_fffc, TGT_DRAM);
      rqa(SRC_CPU, YES, 32'h0100_0000, TGT_DRAM);
    end
    flg(NO, NO, NO, NO, NO, 2'h0);
    rqa(SRC_HUB, YES, 32'hfee0_0000, TGT_INTR);
    rqa(SRC_GFX, YES, 32'hfeef_fffc, TGT_INTR);
    rqa(SRC_CPU, YES, 32'hfee0_0100, TGT_HUB);
    rqa(SRC_HUB, NO, 32'hfee0_0200, TGT_HUB);
    for (int k = 0; k < 2; k++) begin
      flg(NO, YES, NO, k[0], YES, 2'h0);
      ad = 32'hfeda_0000 + ($random(seed) & 32'h1_fffc);
      rq(SRC_CPU, YES, ad, k ? TGT_DRAM : TGT_HUB,
         k ? (32'h000a_0000 | (ad & 32'h1_ffff)) : ad);
      rq(SRC_HUB, NO, ad, k ? TGT_DRAM : TGT_HUB, k ? 32'h0 : ad);
      rqa(SRC_GFX, YES, ad, k ? TGT_DISCARD : TGT_HUB);
    end
    flg(NO, YES, NO, YES, NO, 2'h0);
    rqa(SRC_CPU, NO, 32'hfedb_fffc, TGT_HUB);
    rq(SRC_CPU, NO, 32'hfedb_fffc, TGT_DRAM, 32'h000b_fffc, YES);
    for (int z = 0; z < 4; z++) begin
      bs = 32'h1000_0000 - (32'h0002_0000 << z);
      flg(NO, YES, YES, NO, NO, 2'(z));
      rqa(SRC_CPU, NO, bs, TGT_DRAM, YES);
      rqa(SRC_CPU, YES, 32'h0fff_fffc, TGT_SPECIAL);
      rqa(SRC_CPU, NO, bs, TGT_SPECIAL);
      rqa(SRC_CPU, YES, bs - 4, TGT_DRAM);
      rq(SRC_HUB, NO, bs, TGT_DRAM, 32'h0);
      rqa(SRC_GFX, YES, bs + 4, TGT_DISCARD);
    end
    flg(NO, YES, YES, NO, YES, 2'h3);
    rqa(SRC_CPU, YES, bs, TGT_DRAM);
    flg(NO, NO, YES, NO, YES, 2'h3);
    rqa(SRC_CPU, NO, bs, TGT_SPECIAL, YES);
    flg(NO, YES, NO, NO, NO, 2'h3);
    rqa(SRC_CPU, NO, bs, TGT_DRAM);
    rqa(SRC_HUB, YES, bs, TGT_DRAM);
    for (int g = 0; g < 2; g++) begin
      bs = 32'hc000_0000 + (g << 24);
      rqa(SRC_CPU, NO, bs, TGT_GFX);
      rqa(SRC_HUB, YES, bs + 32'h00ff_ffff, TGT_GFX);
    end
    rqa(SRC_CPU, YES, 32'hbfff_ffff, TGT_HUB);
    rqa(SRC_GFX, NO, 32'hc200_0000, TGT_HUB);
    for (int r = 0; r < 8; r++) begin
      ad = 32'h1000_0000 + ($random(seed) & 32'h3fff_fffc);
      rqa(SRC_CPU, r[0], ad, TGT_HUB);
      rqa(SRC_HUB, r[1], (ad & 32'h0eff_fffc) | 32'h0100_0000, TGT_DRAM);
    end
    // code 7 is not a size and must leave the 256 MB setting alone
    for (int c = 0; c < 8; c++) begin
      load_size(3'(c));
      m = (c == 7) ? 6 : c;
      check(32'(aperture_size), 32'(m));
      check(aperture_base, 32'hdfff_ffff & ~((32'h40_0000 << m) - 1));
      if (c == 0) begin
        rqa(SRC_CPU, NO, 32'hd000_0000, TGT_HUB);
      end
    end
    agent.idle();
    for (int i = 0; i < 16; i++) begin
      fr[i] = FRAME_W'($random(seed));
      xlat_wr_en    <= YES;
      xlat_wr_index <= 4'(i);
      xlat_wr_frame <= fr[i];
      @(posedge core_clk);
    end
    xlat_wr_en <= NO;
    for (int i = 0; i < 18; i++) begin
      ad = 32'hd000_0000 + (i << 12) + ($random(seed) & 32'hffc);
      rq(source_t'(i % 3), i[0], ad, TGT_DRAM, {fr[i % 16], ad[11:0]});
    end
    agent.idle();
    repeat (5) @(posedge core_clk);
    check(32'(expq.size()), 32'h0);
    test_done();
  end

  // about 250 requests at most a few cycles each; far beyond that is a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
endmodule : tb_system_address_decoder
